// >>> hdl/rst_ctl_pkg.sv
package rst_ctl_pkg;

  // Register map
  localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'hC9;
  localparam int         BIAS_FORCE_BIT         = 4;
  localparam logic [7:0] REGULATOR_CONTROL_RST  = 8'h10;
  localparam logic [7:0] REGULATOR_WRITE_MASK   = 8'h10;

  // Reset values applied to the rest of the device
  localparam logic [7:0]  PORT_LATCH_RST = 8'hFF;
  localparam logic [15:0] PC_RST         = 16'h0000;
  localparam logic [7:0]  SP_RST         = 8'h07;
  localparam logic [3:0]  WDT_DIV        = 4'hC;
  localparam logic [3:0]  WDT_DIV_LAST   = 4'hB;

  // Precision oscillator bias settling
  localparam int BIAS_SETTLE_NS  = 4000;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset cause
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b001,
    CAUSE_POR  = 3'b010,
    CAUSE_VMON = 3'b100
  } cause_type;

  // Register bus access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  // Reset-state outputs toward the core and ports
  typedef struct packed {
    logic        core_halt;
    logic        sfr_load_default;
    logic        int_disable;
    logic        tmr_disable;
    logic        ram_hold;
    logic        pc_load;
    logic [15:0] pc_value;
    logic        sp_load;
    logic [7:0]  sp_value;
    logic        osc_sel_internal;
    logic        port_force;
    logic [7:0]  port_latch;
    logic        port_open_drain;
    logic        weak_pullup_en;
  } core_ctl_type;

endpackage

// >>> hdl/reset_state_and_osc_bias_control.sv
`timescale 1ns/10ps
// Function
// - Bias-force bit 4 keeps oscillator bias on
// - Reserved bits 6,5,0 read zero
// - Unused bits 7,3:1 read zero, ignore writes
// - Core halted while in reset
// - Registers load defaults during reset
// - Port latches all ones, open drain
// - Weak pull-ups on during and after reset
// - Reset disables interrupts and timers
// - Reset leaves data RAM untouched
// - Stack pointer returns to default value
// - Power-on reset: pin floats, pull-up off
// - Monitor reset: pin driven low
// - Reset clears PC, selects internal oscillator until exit
// - Watchdog enabled, clocked sysclk divided by 12
// - First fetch from address 0x0000
// - Power-on exit sets power-on flag
module reset_state_and_osc_bias_control
  import rst_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Reset sources from pins or analog monitors
  input  wire logic         por_req,
  input  wire logic         vmon_req,
  input  wire logic         other_req,
  // Register access
  input  wire sfr_req_type  sfr_req,
  output logic [7:0]        sfr_rdata,
  // Reset pin, four-signal form
  input  wire logic         rst_pin_in,
  output logic              rst_pin_out,
  output logic              rst_pin_oe,
  output logic              rst_pin_pullup_en,
  // Core and port control
  output core_ctl_type      core_ctl,
  output logic              in_reset,
  // Oscillator bias and watchdog
  output logic              precision_osc_bias_force,
  output logic              bias_settled,
  output logic              wdt_enable,
  output logic              wdt_tick,
  // Reset-cause flag
  output logic              power_on_flag
);

  logic [1:0]  por_sync_r;
  logic [1:0]  vmon_sync_r;
  logic [1:0]  oth_sync_r;
  logic [1:0]  pin_sync_r;
  logic        hold_r;
  logic        hold_nxt;
  cause_type   cause_r;
  logic [7:0]  reg_ctl_r;
  logic [3:0]  wdt_cnt_r;
  logic [9:0]  settle_cnt_r;
  logic        exit_pulse_r;
  logic [1:0]  pin_own_dly_r;
  logic        pin_own;
  logic        pin_mask;

  // Two-flop synchronisers for all asynchronous sources
  always_ff @(posedge clk) begin
    if (rst) begin
      por_sync_r  <= 2'h3;
      vmon_sync_r <= 2'h0;
      oth_sync_r  <= 2'h0;
      pin_sync_r  <= 2'h3;
    end else begin
      por_sync_r  <= {por_sync_r[0], por_req};
      vmon_sync_r <= {vmon_sync_r[0], vmon_req};
      oth_sync_r  <= {oth_sync_r[0], other_req};
      pin_sync_r  <= {pin_sync_r[0], rst_pin_in};
    end
  end

  // Pin is owned while driven low or left without its pull-up
  assign pin_own = rst_pin_oe | ~rst_pin_pullup_en;

  // Owned state delayed to cover the synchroniser latency
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_own_dly_r <= 2'h3;
    end else begin
      pin_own_dly_r <= {pin_own_dly_r[0], pin_own};
    end
  end

  // Own drive or floating level must not hold reset after release
  assign pin_mask = pin_own | pin_own_dly_r[0] | pin_own_dly_r[1];

  // Any synchronised source holds the device in reset
  assign hold_nxt = por_sync_r[1] | vmon_sync_r[1] | oth_sync_r[1]
                  | (~pin_sync_r[1] & ~pin_mask);

  // Reset state, released on a single clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r       <= 1'b1;
      exit_pulse_r <= 1'b0;
    end else begin
      hold_r       <= hold_nxt;
      exit_pulse_r <= hold_r & ~hold_nxt;
    end
  end

  // Latch which source caused the reset; power-on dominates
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_r <= CAUSE_POR;
    end else if (por_sync_r[1]) begin
      cause_r <= CAUSE_POR;
    end else if (vmon_sync_r[1] && cause_r != CAUSE_POR) begin
      cause_r <= CAUSE_VMON;
    end else if (!hold_r && !hold_nxt) begin
      cause_r <= CAUSE_NONE;
    end
  end

  // Power-on flag set on exit from power-on reset, cleared by others
  always_ff @(posedge clk) begin
    if (rst) begin
      power_on_flag <= 1'b0;
    end else if (exit_pulse_r) begin
      power_on_flag <= (cause_r == CAUSE_POR);
    end
  end

  // Reset pin behaviour by cause
  always_comb begin
    rst_pin_out       = 1'b0;
    rst_pin_oe        = hold_r && (cause_r == CAUSE_VMON);
    rst_pin_pullup_en = !(hold_r && (cause_r == CAUSE_POR));
  end

  // Regulator control register; only bias-force bit is writable
  always_ff @(posedge clk) begin
    if (rst || hold_r) begin
      reg_ctl_r <= REGULATOR_CONTROL_RST;
    end else if (sfr_req.wr && sfr_req.addr == REGULATOR_CONTROL_ADDR) begin
      reg_ctl_r <= sfr_req.wdata & REGULATOR_WRITE_MASK;
    end
  end

  assign precision_osc_bias_force = reg_ctl_r[BIAS_FORCE_BIT];

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd && sfr_req.addr == REGULATOR_CONTROL_ADDR) begin
      sfr_rdata <= reg_ctl_r & REGULATOR_WRITE_MASK;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // Settling status after the bias is switched back on
  always_ff @(posedge clk) begin
    if (rst || !precision_osc_bias_force) begin
      settle_cnt_r <= 10'h000;
    end else if (settle_cnt_r != 10'(BIAS_SETTLE_CYC)) begin
      settle_cnt_r <= settle_cnt_r + 10'h001;
    end
  end

  assign bias_settled = (settle_cnt_r == 10'(BIAS_SETTLE_CYC));

  // Watchdog clock: one-cycle enable every twelve system clocks
  always_ff @(posedge clk) begin
    if (rst || hold_r) begin
      wdt_cnt_r <= 4'h0;
      wdt_tick  <= 1'b0;
    end else if (wdt_cnt_r == WDT_DIV_LAST) begin
      wdt_cnt_r <= 4'h0;
      wdt_tick  <= 1'b1;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + 4'h1;
      wdt_tick  <= 1'b0;
    end
  end

  // Watchdog enabled from reset exit onward
  always_ff @(posedge clk) begin
    if (rst || hold_r) begin
      wdt_enable <= 1'b0;
    end else begin
      wdt_enable <= 1'b1;
    end
  end

  // Control bundle to core and ports
  always_comb begin
    in_reset                  = hold_r;
    core_ctl.core_halt        = hold_r;
    core_ctl.sfr_load_default = hold_r;
    core_ctl.int_disable      = hold_r;
    core_ctl.tmr_disable      = hold_r;
    core_ctl.ram_hold         = 1'b1;
    core_ctl.pc_load          = hold_r;
    core_ctl.pc_value         = PC_RST;
    core_ctl.sp_load          = hold_r;
    core_ctl.sp_value         = SP_RST;
    core_ctl.osc_sel_internal = hold_r;
    core_ctl.port_force       = hold_r;
    core_ctl.port_latch       = PORT_LATCH_RST;
    core_ctl.port_open_drain  = hold_r;
    core_ctl.weak_pullup_en   = 1'b1;
  end

  // Assertions
  // Unwritable bits never hold a one
  a_reg_bits_zero: assert property (@(posedge clk) disable iff (rst)
    (reg_ctl_r & ~REGULATOR_WRITE_MASK) == 8'h00)
    else $error("regulator control unused bits set");

  // Reserved bits read back as zero
  a_reg_read_zero: assert property (@(posedge clk) disable iff (rst)
    sfr_req.rd && sfr_req.addr == REGULATOR_CONTROL_ADDR |=> (sfr_rdata & 8'h61) == 8'h00)
    else $error("reserved bits read nonzero");

  // Bias-force bit follows an accepted write
  a_bias_write: assert property (@(posedge clk) disable iff (rst)
    !hold_r && !hold_nxt && sfr_req.wr && sfr_req.addr == REGULATOR_CONTROL_ADDR
    |=> precision_osc_bias_force == $past(sfr_req.wdata[4]))
    else $error("bias force bit did not follow write");

  // Reset state restores the bias-force default
  a_bias_reset: assert property (@(posedge clk) disable iff (rst)
    hold_r |=> precision_osc_bias_force)
    else $error("bias force not restored in reset");

  // Core, interrupts and timers stopped in reset
  a_halt_core: assert property (@(posedge clk) disable iff (rst)
    hold_r |-> core_ctl.core_halt && core_ctl.int_disable && core_ctl.tmr_disable)
    else $error("core not halted in reset");

  // Port latches high, open drain, pull-ups on
  a_port_state: assert property (@(posedge clk) disable iff (rst)
    hold_r |-> core_ctl.port_latch == 8'hFF && core_ctl.port_open_drain
    && core_ctl.weak_pullup_en)
    else $error("port state wrong in reset");

  // Monitor reset drives the pin low
  a_pin_vmon: assert property (@(posedge clk) disable iff (rst)
    hold_r && cause_r == CAUSE_VMON |-> rst_pin_oe && !rst_pin_out)
    else $error("reset pin not driven low");

  // Power-on reset leaves the pin floating
  a_pin_por: assert property (@(posedge clk) disable iff (rst)
    hold_r && cause_r == CAUSE_POR |-> !rst_pin_oe && !rst_pin_pullup_en)
    else $error("reset pin driven during power-on");

  // Power-on exit sets the flag two cycles on
  a_por_flag: assert property (@(posedge clk) disable iff (rst)
    hold_r && !hold_nxt && cause_r == CAUSE_POR |=> ##1 power_on_flag)
    else $error("power-on flag not set");

  // Watchdog enable pulse every twelve clocks
  a_wdt_period: assert property (@(posedge clk) disable iff (rst || hold_r)
    wdt_tick |-> ##12 wdt_tick)
    else $error("watchdog tick period wrong");

  // Program counter reloads to zero
  a_pc_zero: assert property (@(posedge clk) disable iff (rst)
    core_ctl.pc_load |-> core_ctl.pc_value == 16'h0000)
    else $error("program counter default wrong");

  // Pin let go and pull-up restored once out of reset
  a_pin_released: assert property (@(posedge clk) disable iff (rst)
    !hold_r |-> !rst_pin_oe && rst_pin_pullup_en)
    else $error("reset pin still held after exit");

  // Watchdog starts on the cycle after reset exit
  a_wdt_start: assert property (@(posedge clk) disable iff (rst)
    $fell(hold_r) |=> wdt_enable)
    else $error("watchdog not enabled after exit");

  // Watchdog stopped and silent while in reset
  a_wdt_hold: assert property (@(posedge clk) disable iff (rst)
    hold_r |=> !wdt_enable && !wdt_tick)
    else $error("watchdog running in reset");

  // No second tick within eight cycles of the last one
  a_tick_gap: assert property (@(posedge clk) disable iff (rst || hold_r)
    wdt_tick |=> !wdt_tick [*8])
    else $error("watchdog ticks too close");

  // Unmapped or idle read cycles return zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    !(sfr_req.rd && sfr_req.addr == REGULATOR_CONTROL_ADDR)
    |=> sfr_rdata == 8'h00)
    else $error("unmapped read nonzero");

  // Monitor reset exit leaves the power-on flag clear
  a_vmon_flag: assert property (@(posedge clk) disable iff (rst)
    hold_r && !hold_nxt && cause_r == CAUSE_VMON |=> ##1 !power_on_flag)
    else $error("power-on flag set after monitor reset");

  // Settling restarts each time the bias is forced on again
  a_settle_restart: assert property (@(posedge clk) disable iff (rst)
    $rose(precision_osc_bias_force) |-> !bias_settled)
    else $error("bias settled flag not restarted");

  c_por_exit:  cover property (@(posedge clk) hold_r ##1 !hold_r ##1 power_on_flag);
  c_vmon_hold: cover property (@(posedge clk) rst_pin_oe);
  c_bias_off:  cover property (@(posedge clk) !precision_osc_bias_force);
  c_settled:   cover property (@(posedge clk) $rose(bias_settled));
  c_ext_reset: cover property (@(posedge clk) hold_r && !rst_pin_oe && rst_pin_pullup_en);

endmodule

// >>> tb/reset_state_and_osc_bias_control_bench.sv
`timescale 1ns/10ps
module reset_state_and_osc_bias_control_bench;
  import rst_ctl_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         por_req = 1'b0;
  logic         vmon_req = 1'b0;
  logic         other_req = 1'b0;
  logic         pin_pull_low = 1'b0;
  wire logic    rst_pin_in;
  sfr_req_type  sfr_req = '0;
  logic [7:0]   sfr_rdata;
  logic         rst_pin_out, rst_pin_oe, rst_pin_pullup_en, in_reset;
  core_ctl_type core_ctl;
  logic         precision_osc_bias_force, bias_settled, wdt_enable, wdt_tick, power_on_flag;
  int           n_errors = 0;
  int           total_checks = 0;
  logic [7:0]   rv, w;
  int           n;

  reset_state_and_osc_bias_control reset_state_and_osc_bias_control_inst (
    .clk                      (clk),
    .rst                      (rst),
    .por_req                  (por_req),
    .vmon_req                 (vmon_req),
    .other_req                (other_req),
    .sfr_req                  (sfr_req),
    .sfr_rdata                (sfr_rdata),
    .rst_pin_in               (rst_pin_in),
    .rst_pin_out              (rst_pin_out),
    .rst_pin_oe               (rst_pin_oe),
    .rst_pin_pullup_en        (rst_pin_pullup_en),
    .core_ctl                 (core_ctl),
    .in_reset                 (in_reset),
    .precision_osc_bias_force (precision_osc_bias_force),
    .bias_settled             (bias_settled),
    .wdt_enable               (wdt_enable),
    .wdt_tick                 (wdt_tick),
    .power_on_flag            (power_on_flag)
  );

  // Reset pin: own drive, else external pull-down, else pull-up; floats low
  assign rst_pin_in = rst_pin_oe ? rst_pin_out : (pin_pull_low ? 1'b0 : rst_pin_pullup_en);

  // Free-running system clock
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Bounded wait for the reset state to reach a level
  task automatic wait_rst(input logic v);
    for (int i = 0; i < 50 && in_reset !== v; i++) @(negedge clk);
    if (in_reset !== v) begin
      n_errors++;
      $display("BAD %0t reset state stuck", $time);
      print_verdict();
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    sfr_req = '0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    sfr_req = '0;
    d = sfr_rdata;
  endtask

  // Register image after a write: only the bias-force bit holds
  function automatic logic [7:0] reg_exp(input logic [7:0] d);
    return {3'b000, d[4], 4'b0000};
  endfunction

  task automatic core_chk(input logic r);
    check({core_ctl.core_halt, core_ctl.sfr_load_default, core_ctl.int_disable,
           core_ctl.tmr_disable, core_ctl.port_force, core_ctl.port_open_drain,
           core_ctl.pc_load, core_ctl.sp_load, core_ctl.osc_sel_internal},
          {23'h0, {9{r}}}, "core");
    check({core_ctl.port_latch, core_ctl.pc_value, core_ctl.sp_value},
          {8'hFF, 16'h0000, SP_RST}, "ports");
    check({core_ctl.ram_hold, core_ctl.weak_pullup_en}, 2'b11, "ram pullup");
  endtask

  // Main sequence
  initial begin
    void'($urandom(27190));
    repeat (4) @(negedge clk);
    core_chk(1'b1);
    check({rst_pin_oe, rst_pin_pullup_en}, 2'b00, "por pin");
    rst = 1'b0;
    wait_rst(1'b0);
    core_chk(1'b0);
    check(core_ctl.osc_sel_internal, 1'b0, "osc sel");
    repeat (3) @(negedge clk);
    check({wdt_enable, power_on_flag}, 2'b11, "exit flags");
    sfr_read(REGULATOR_CONTROL_ADDR, rv);
    check(rv, 8'h10, "reg reset");
    $display("test reset exit done");
    // Watchdog tick spacing
    for (n = 0; n < 30 && wdt_tick !== 1'b1; n++) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (n < 30 && wdt_tick !== 1'b1);
    check(n, 12, "wdt period");
    $display("test watchdog done");
    // Register writes, corners then random
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 8'hFF : (i == 1) ? 8'hEF : 8'($urandom);
      sfr_write(REGULATOR_CONTROL_ADDR, w);
      check(precision_osc_bias_force, w[4], "bias bit");
      sfr_read(REGULATOR_CONTROL_ADDR, rv);
      check(rv, reg_exp(w), "reg read");
      sfr_read(8'(REGULATOR_CONTROL_ADDR + 8'($urandom_range(1, 255))), rv);
      check(rv, 8'h00, "unmapped");
    end
    $display("test register done");
    // Bias settling after off then on
    sfr_write(REGULATOR_CONTROL_ADDR, 8'h00);
    check(bias_settled, 1'b0, "bias off");
    sfr_write(REGULATOR_CONTROL_ADDR, 8'h10);
    for (n = 0; n < 600 && bias_settled !== 1'b1; n++) @(negedge clk);
    check(n >= 495 && n <= 505, 1'b1, "settle time");
    $display("test settle done");
    // Supply-monitor reset
    sfr_write(REGULATOR_CONTROL_ADDR, 8'h00);
    vmon_req = 1'b1;
    wait_rst(1'b1);
    check({rst_pin_oe, rst_pin_out, rst_pin_pullup_en}, 3'b101, "vmon pin");
    core_chk(1'b1);
    vmon_req = 1'b0;
    wait_rst(1'b0);
    @(negedge clk);
    check({wdt_enable, rst_pin_oe}, 2'b10, "vmon exit");
    sfr_read(REGULATOR_CONTROL_ADDR, rv);
    check(rv, 8'h10, "reg default");
    check(in_reset, 1'b0, "vmon release");
    $display("test monitor reset done");
    // Power-on reset with a write attempted inside it
    sfr_write(REGULATOR_CONTROL_ADDR, 8'h00);
    por_req = 1'b1;
    wait_rst(1'b1);
    @(negedge clk);
    check({rst_pin_oe, rst_pin_pullup_en}, 2'b00, "por pin");
    sfr_write(REGULATOR_CONTROL_ADDR, 8'h00);
    por_req = 1'b0;
    wait_rst(1'b0);
    repeat (3) @(negedge clk);
    check({power_on_flag, rst_pin_pullup_en, in_reset}, 3'b110, "por exit");
    sfr_read(REGULATOR_CONTROL_ADDR, rv);
    check(rv, 8'h10, "write in reset");
    $display("test power-on reset done");
    // Reset from the other source, then from the pin pulled low outside
    for (int k = 0; k < 2; k++) begin
      other_req = (k == 0);
      pin_pull_low = (k == 1);
      wait_rst(1'b1);
      check({rst_pin_oe, rst_pin_pullup_en}, 2'b01, "ext pin");
      core_chk(1'b1);
      other_req = 1'b0;
      pin_pull_low = 1'b0;
      wait_rst(1'b0);
      repeat (3) @(negedge clk);
      check({power_on_flag, wdt_enable, in_reset}, 3'b010, "ext exit");
    end
    $display("test other reset done");
    // Combined reset raised again in mid-run
    sfr_write(REGULATOR_CONTROL_ADDR, 8'h00);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    core_chk(1'b1);
    check({rst_pin_oe, rst_pin_pullup_en}, 2'b00, "rst pin");
    rst = 1'b0;
    wait_rst(1'b0);
    repeat (3) @(negedge clk);
    check({power_on_flag, wdt_enable, in_reset}, 3'b110, "rst exit");
    sfr_read(REGULATOR_CONTROL_ADDR, rv);
    check(rv, 8'h10, "rst default");
    $display("test second reset done");
    print_verdict();
  end
endmodule
